// >>> bench/gpi_flag_and_level_readout_bench.sv
// Self-checking bench for the general input flag and level readout.
`timescale 1ns/10ps
`default_nettype none
module gpi_flag_and_level_readout_bench;
    logic        CLK_I = 1'b0, RESETN_I = 1'b0, RD_VALID_O;
    logic        EV_LOAD_I = 1'b0, EV_STATE_I = 1'b0, RD_STB_I = 1'b0;
    logic [6:0]  EV_CODE_I = '0;
    logic [7:0]  ROW_I, RD_ADDR_I = '0, RD_DATA_O;
    logic [10:0] COL_I;
    logic [18:0] INT_EN_I = '0, INT_HIGH_I = '0, want = '0, FLAGS_O;
    int          failures = 0, cmp_count = 0, cycles = 0;
    initial forever #20 CLK_I = ~CLK_I;
    pin_source PINS (.want_i(want), .row_o(ROW_I), .col_o(COL_I));
    gpi_flag_and_level_readout DUT (.CLK_I, .RESETN_I, .ROW_I, .COL_I,
        .INT_EN_I, .INT_HIGH_I, .EV_LOAD_I, .EV_STATE_I, .EV_CODE_I,
        .RD_STB_I, .RD_ADDR_I, .RD_DATA_O, .RD_VALID_O, .FLAGS_O);
    task automatic chk(string what, logic [18:0] seen, logic [18:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic rd(logic [7:0] a, logic [7:0] exp, bit judge = 1'b1);
        @(posedge CLK_I) RD_STB_I <= 1'b1;
        RD_ADDR_I <= a;
        @(posedge CLK_I) RD_STB_I <= 1'b0;
        #1 chk("read valid", 19'(RD_VALID_O), 19'h00001);
        if (judge) chk("read data", 19'(RD_DATA_O), 19'(exp));
    endtask : rd
    task automatic t_level(logic [18:0] v);
        @(posedge CLK_I) want <= v;
        repeat (5) @(posedge CLK_I);
        rd(8'h16, v[7:0]);
        rd(8'h17, v[15:8]);
    endtask : t_level
    task automatic t_slot(logic s, logic [6:0] c);
        @(posedge CLK_I) EV_LOAD_I <= 1'b1;
        EV_STATE_I <= s;
        EV_CODE_I <= c;
        @(posedge CLK_I) EV_LOAD_I <= 1'b0;
        rd(8'h12, {s, c});
    endtask : t_slot
    task automatic t_flags(logic [18:0] en, hi, from, to);
        logic [18:0] e;
        e = en & ((hi & ~from & to) | (~hi & from & ~to));
        @(posedge CLK_I) INT_EN_I <= en;
        INT_HIGH_I <= hi;
        want <= from;
        repeat (5) @(posedge CLK_I);
        for (int i = 0; i < 3; i++) rd(8'(8'h13 + i), 8'h00, 1'b0);
        @(posedge CLK_I) want <= to;
        repeat (5) @(posedge CLK_I);
        chk("flags", FLAGS_O, e);
        rd(8'h13, e[7:0]);
        rd(8'h14, e[15:8]);
        rd(8'h15, {5'h00, e[18:16]});
        rd(8'h13, 8'h00);
        rd(8'h15, 8'h00);
        chk("flags after reads", FLAGS_O, 19'h00000);
    endtask : t_flags
    // A second flag rises at the very edge that a read captures the first.
    task automatic t_race;
        @(posedge CLK_I) INT_EN_I <= 19'h00003;
        INT_HIGH_I <= 19'h00003;
        want <= 19'h00000;
        repeat (5) @(posedge CLK_I);
        rd(8'h13, 8'h00, 1'b0);
        @(posedge CLK_I) want <= 19'h00001;
        repeat (5) @(posedge CLK_I);
        @(posedge CLK_I) want <= 19'h00003;
        @(posedge CLK_I);
        rd(8'h13, 8'h01);
        chk("flag kept", FLAGS_O, 19'h00002);
        rd(8'h13, 8'h02);
    endtask : t_race
    // A reset in mid-run clears a raised flag, and a pin that is already
    // active when reset ends raises none.
    task automatic t_reset;
        @(posedge CLK_I) want <= 19'h00000;
        repeat (5) @(posedge CLK_I);
        @(posedge CLK_I) want <= 19'h00001;
        repeat (5) @(posedge CLK_I);
        chk("flag before reset", FLAGS_O, 19'h00001);
        @(posedge CLK_I) RESETN_I <= 1'b0;
        repeat (16) @(posedge CLK_I);
        #1 chk("flags in reset", FLAGS_O, 19'h00000);
        chk("data in reset", 19'(RD_DATA_O), 19'h00000);
        @(posedge CLK_I) RESETN_I <= 1'b1;
        repeat (4) @(posedge CLK_I);
        rd(8'h16, 8'h01);
        chk("no flag after reset", FLAGS_O, 19'h00000);
    endtask : t_reset
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run
    always @(posedge CLK_I) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            complete_run;
        end
    end
    initial begin
        repeat (16) @(posedge CLK_I);
        RESETN_I <= 1'b1;
        repeat (4) @(posedge CLK_I);
        #1 chk("valid after reset", 19'(RD_VALID_O), 19'h00000);
        chk("data after reset", 19'(RD_DATA_O), 19'h00000);
        chk("flags after reset", FLAGS_O, 19'h00000);
        t_level(19'h2a5a5);
        t_level(19'h55a5a);
        t_slot(1'b1, 7'h5a);
        t_slot(1'b0, 7'h7f);
        t_flags(19'h7ffff, 19'h7ffff, 19'h00000, 19'h7ffff);
        t_flags(19'h55555, 19'h00000, 19'h7ffff, 19'h00000);
        t_flags(19'h7ffff, 19'h0f0f0, 19'h3c3c3, 19'h5a5a5);
        t_race;
        t_reset;
        complete_run;
    end
endmodule : gpi_flag_and_level_readout_bench
bind gpi_flag_and_level_readout gpi_readout_properties PROPS (.CLK_I,
    .RESETN_I, .ROW_I, .COL_I, .INT_EN_I, .INT_HIGH_I, .EV_LOAD_I,
    .EV_STATE_I, .EV_CODE_I, .RD_STB_I, .RD_ADDR_I, .RD_DATA_O,
    .RD_VALID_O, .FLAGS_O);
`default_nettype wire

// >>> bench/gpi_readout_properties.sv
// Concurrent checks on the read port and flag outputs of the readout block.
`timescale 1ns/10ps
`default_nettype none
module gpi_readout_properties (
    input wire logic        CLK_I,
    input wire logic        RESETN_I,
    input wire logic [7:0]  ROW_I,
    input wire logic [10:0] COL_I,
    input wire logic [18:0] INT_EN_I,
    input wire logic [18:0] INT_HIGH_I,
    input wire logic        EV_LOAD_I,
    input wire logic        EV_STATE_I,
    input wire logic [6:0]  EV_CODE_I,
    input wire logic        RD_STB_I,
    input wire logic [7:0]  RD_ADDR_I,
    input wire logic [7:0]  RD_DATA_O,
    input wire logic        RD_VALID_O,
    input wire logic [18:0] FLAGS_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);
    a_valid_after_strobe: assert property (
        RD_VALID_O == $past(RD_STB_I)) else $error("valid not after strobe");
    a_row_flag_read: assert property (
        RD_STB_I && RD_ADDR_I == 8'h13 |=> RD_DATA_O == $past(FLAGS_O[7:0]))
        else $error("row flag byte wrong");
    a_col_flag_read: assert property (
        RD_STB_I && RD_ADDR_I == 8'h14 |=> RD_DATA_O == $past(FLAGS_O[15:8]))
        else $error("column flag byte wrong");
    a_high_flag_read: assert property (
        RD_STB_I && RD_ADDR_I == 8'h15
        |=> RD_DATA_O == {5'h00, $past(FLAGS_O[18:16])})
        else $error("upper flag byte wrong");
    // Three stable cycles cover the synchroniser lag before the level is read.
    a_row_level_read: assert property (
        $stable(ROW_I)[*3] ##0 RD_STB_I && RD_ADDR_I == 8'h16
        |=> RD_DATA_O == $past(ROW_I)) else $error("row level byte wrong");
    a_col_level_read: assert property (
        $stable(COL_I)[*3] ##0 RD_STB_I && RD_ADDR_I == 8'h17
        |=> RD_DATA_O == $past(COL_I[7:0]))
        else $error("column level byte wrong");
    a_slot_read_back: assert property (
        EV_LOAD_I ##1 !EV_LOAD_I ##1 !EV_LOAD_I && RD_STB_I
        && RD_ADDR_I == 8'h12
        |=> RD_DATA_O == $past({EV_STATE_I, EV_CODE_I}, 3))
        else $error("event slot byte wrong");
    a_flag_fall_read: assert property (
        |(~FLAGS_O & $past(FLAGS_O)) |-> $past(RD_STB_I))
        else $error("flag cleared without a read");
    a_disabled_quiet: assert property (
        !(|(FLAGS_O & ~$past(FLAGS_O) & ~$past(INT_EN_I))))
        else $error("disabled input raised a flag");
endmodule : gpi_readout_properties
`default_nettype wire

// >>> bench/pin_source.sv
// Switch and logic levels on the row and column lines.
`timescale 1ns/10ps
`default_nettype none
module pin_source (
    input  wire logic [18:0] want_i,
    output wire logic [7:0]  row_o,
    output wire logic [10:0] col_o
);
    // Pins move a few ns after the bench changes them, unrelated to sampling.
    assign #3 {col_o, row_o} = want_i;
endmodule : pin_source
`default_nettype wire

// >>> core/gpi_flag_and_level_readout.sv
// General input flag, level and sixteenth event slot register readout.
`timescale 1ns/10ps
`default_nettype none
module gpi_flag_and_level_readout (
    input  wire logic                                   CLK_I,
    input  wire logic                                   RESETN_I,
    input  wire logic [gpi_readout_pkg::NUM_ROWS-1:0]   ROW_I,
    input  wire logic [gpi_readout_pkg::NUM_COLS-1:0]   COL_I,
    input  wire logic [gpi_readout_pkg::NUM_INPUTS-1:0] INT_EN_I,
    input  wire logic [gpi_readout_pkg::NUM_INPUTS-1:0] INT_HIGH_I,
    input  wire logic                                   EV_LOAD_I,
    input  wire logic                                   EV_STATE_I,
    input  wire logic [gpi_readout_pkg::CODE_WIDTH-1:0] EV_CODE_I,
    input  wire logic                                   RD_STB_I,
    input  wire logic [7:0]                             RD_ADDR_I,
    output var  logic [gpi_readout_pkg::REG_WIDTH-1:0]  RD_DATA_O,
    output var  logic                                   RD_VALID_O,
    output var  logic [gpi_readout_pkg::NUM_INPUTS-1:0] FLAGS_O
);
    import gpi_readout_pkg::*;

    // One-hot select of the flag register at an address, or zero.
    function automatic logic [FLAG_GROUPS-1:0] flag_select(
        input logic [7:0] addr
    );
        logic [FLAG_GROUPS-1:0] sel;
        sel = '0;
        case (addr)
            ADDR_INPUT_FLAG_ROWS:      sel = 3'h1;
            ADDR_INPUT_FLAG_COLS_LOW:  sel = 3'h2;
            ADDR_INPUT_FLAG_COLS_HIGH: sel = 3'h4;
            default:                   sel = 3'h0;
        endcase
        return sel;
    endfunction : flag_select

    logic                         rst_meta_ff;
    logic                         rst_sync_ff;
    logic [NUM_INPUTS-1:0]        level;
    logic [NUM_INPUTS-1:0]        prev_level_ff;
    logic [NUM_INPUTS-1:0]        active;
    logic [NUM_INPUTS-1:0]        prev_active;
    logic [NUM_INPUTS-1:0]        flag_set;
    logic [NUM_INPUTS-1:0]        flag_clr;
    logic [NUM_INPUTS-1:0]        nxt_flags;
    logic [FLAG_GROUPS-1:0]       rd_sel;
    logic                         slot_state_ff;
    logic [CODE_WIDTH-1:0]        slot_code_ff;
    logic [REG_WIDTH-1:0]         nxt_rd_data;
    logic [ARM_STAGES-1:0]        arm_ff;

    // Reset is asserted at once but released only after two clock edges,
    // so no flop leaves reset on a marginal edge.
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // Bits 7 to 0 are row lines, bits 18 to 8 column lines, in input order.
    pin_sync #(
        .WIDTH (NUM_INPUTS)
    ) u_pin_sync (
        .clk_i   (CLK_I),
        .rst_n_i (rst_sync_ff),
        .async_i ({COL_I, ROW_I}),
        .sync_o  (level)
    );

    always_ff @(posedge CLK_I or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            prev_level_ff <= '0;
        end else begin
            prev_level_ff <= level;
        end
    end

    // An enabled input raises its flag when it enters its active level; holding
    // the level does not re-raise a flag that a read has cleared.
    // Edge detection waits until the synchroniser and the previous level
    // both hold real pin data, so a pin that already sits at its active
    // level when reset ends does not raise a false flag.
    always_ff @(posedge CLK_I or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            arm_ff <= '0;
        end else begin
            arm_ff <= {arm_ff[ARM_STAGES-2:0], 1'b1};
        end
    end

    assign active      = ~(level ^ INT_HIGH_I);
    assign prev_active = ~(prev_level_ff ^ INT_HIGH_I);
    assign flag_set    = INT_EN_I & active & ~prev_active
                       & {NUM_INPUTS{arm_ff[ARM_STAGES-1]}};

    assign rd_sel = RD_STB_I ? flag_select(RD_ADDR_I) : '0;

    // Apart from reset, each flag is cleared only by a read of its own register, and only
    // if it was set in the value that the read captures.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_flag
            localparam int GRP = (gi < FLAG_COLS_LSB) ? 0 :
                                 (gi < FLAG_HIGH_LSB) ? 1 : 2;
            assign flag_clr[gi] = rd_sel[GRP] & FLAGS_O[gi];
        end
    endgenerate

    // A set in the same cycle as the clear wins, so no event is lost.
    assign nxt_flags = (FLAGS_O & ~flag_clr) | flag_set;

    always_ff @(posedge CLK_I or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            FLAGS_O <= '0;
        end else begin
            FLAGS_O <= nxt_flags;
        end
    end

    // The event slot is loaded by the event logic; the host cannot write it.
    always_ff @(posedge CLK_I or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            slot_state_ff <= 1'b0;
            slot_code_ff  <= '0;
        end else if (EV_LOAD_I) begin
            slot_state_ff <= EV_STATE_I;
            slot_code_ff  <= EV_CODE_I;
        end
    end

    always_comb begin
        nxt_rd_data = RESET_BYTE;
        case (RD_ADDR_I)
            ADDR_EVENT_SLOT_SIXTEEN:
                nxt_rd_data = {slot_state_ff, slot_code_ff};
            ADDR_INPUT_FLAG_ROWS:
                nxt_rd_data = FLAGS_O[FLAG_ROWS_LSB +: REG_WIDTH];
            ADDR_INPUT_FLAG_COLS_LOW:
                nxt_rd_data = FLAGS_O[FLAG_COLS_LSB +: REG_WIDTH];
            ADDR_INPUT_FLAG_COLS_HIGH:
                nxt_rd_data = {5'h00,
                    FLAGS_O[FLAG_HIGH_LSB +: FLAG_HIGH_BITS]};
            ADDR_INPUT_LEVEL_ROWS:
                nxt_rd_data = level[FLAG_ROWS_LSB +: REG_WIDTH];
            ADDR_INPUT_LEVEL_COLS_LOW:
                nxt_rd_data = level[FLAG_COLS_LSB +: REG_WIDTH];
            default:
                nxt_rd_data = RESET_BYTE;
        endcase
    end

    // Read data is held until the next read so a slow host can sample it.
    always_ff @(posedge CLK_I or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            RD_DATA_O <= RESET_BYTE;
        end else if (RD_STB_I) begin
            RD_DATA_O <= nxt_rd_data;
        end
    end

    always_ff @(posedge CLK_I or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            RD_VALID_O <= 1'b0;
        end else begin
            RD_VALID_O <= RD_STB_I;
        end
    end

endmodule : gpi_flag_and_level_readout
`default_nettype wire

// >>> core/gpi_readout_pkg.sv
// Constants for the general input flag and level readout block.
package gpi_readout_pkg;

    localparam int NUM_ROWS   = 8;
    localparam int NUM_COLS   = 11;
    localparam int NUM_INPUTS = NUM_ROWS + NUM_COLS;
    localparam int REG_WIDTH  = 8;
    localparam int CODE_WIDTH = 7;

    localparam logic [7:0] ADDR_EVENT_SLOT_SIXTEEN   = 8'h12;
    localparam logic [7:0] ADDR_INPUT_FLAG_ROWS      = 8'h13;
    localparam logic [7:0] ADDR_INPUT_FLAG_COLS_LOW  = 8'h14;
    localparam logic [7:0] ADDR_INPUT_FLAG_COLS_HIGH = 8'h15;
    localparam logic [7:0] ADDR_INPUT_LEVEL_ROWS     = 8'h16;
    localparam logic [7:0] ADDR_INPUT_LEVEL_COLS_LOW = 8'h17;

    localparam int FLAG_GROUPS     = 3;
    localparam int FLAG_HIGH_BITS  = 3;
    localparam int FLAG_ROWS_LSB   = 0;
    localparam int FLAG_COLS_LSB   = 8;
    localparam int FLAG_HIGH_LSB   = 16;
    localparam int SLOT_STATE_BIT  = 7;
    localparam int ARM_STAGES      = 3;

    localparam logic [7:0] RESET_BYTE = 8'h00;

endpackage : gpi_readout_pkg

// >>> core/pin_sync.sv
// Two-stage synchroniser for a group of pin levels.
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output var  logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_ff;

    // The first stage is read by the second stage only.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_ff <= '0;
            sync_o  <= '0;
        end else begin
            meta_ff <= async_i;
            sync_o  <= meta_ff;
        end
    end

endmodule : pin_sync
`default_nettype wire
